// File: src/fcs_params.svh
// Purpose: constants of the flash command sequencer (offsets, fields, resets, sizes)
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   shared by the package and both design modules
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

`define FCS_ADDR_W          15
`define FCS_PADDR_W         12

// register byte offsets
`define FCS_OFS_CTRL        12'h000
`define FCS_OFS_ADDR_HI     12'h004
`define FCS_OFS_ADDR_LO     12'h008
`define FCS_OFS_END_HI      12'h00c
`define FCS_OFS_END_LO      12'h010
`define FCS_OFS_WBUF3       12'h014
`define FCS_OFS_WBUF2       12'h018
`define FCS_OFS_WBUF1       12'h01c
`define FCS_OFS_WBUF0       12'h020
`define FCS_OFS_STAT_HI     12'h024
`define FCS_OFS_STAT_LO     12'h028
`define FCS_OFS_MODE        12'h02c

// field positions
`define FCS_CTRL_LAUNCH_BIT 7
`define FCS_STH_DONE_BIT    6
`define FCS_STL_PFAIL_BIT   1
`define FCS_STL_EFAIL_BIT   0
`define FCS_MODE_AREA_BIT   5

// command codes
`define FCS_CMD_NONE        3'h0
`define FCS_CMD_WRITE       3'h1
`define FCS_CMD_ERASE       3'h4

// reset values
`define FCS_RST_BYTE        8'h00
`define FCS_RST_WORD        32'h0000_0000
`define FCS_RST_ADDR        15'h0000

// address masks per variant and erase block sizes
`define FCS_MASK_SMALL      15'h1fff
`define FCS_MASK_WIDE       15'h7fff
`define FCS_END_GRAIN_MASK  15'h7ffc
`define FCS_CODE_BLK_BYTES  15'h0400
`define FCS_DATA_BLK_BYTES  15'h0200

`endif

// File: src/fcs_pkg.sv
// Purpose: types of the flash command sequencer
// Assumes: fcs_params.svh supplies widths
// Notes:   state of each module is one packed struct
`include "fcs_params.svh"

package fcs_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE
    } fcs_state_e;

    // request toward the flash array
    typedef struct packed {
        logic                    req;
        logic                    erase;
        logic                    area;
        logic [`FCS_ADDR_W-1:0]  addr;
        logic [31:0]             wdata;
    } fcs_flash_req_s;

    // answer from the flash array
    typedef struct packed {
        logic ack;
        logic fail;
    } fcs_flash_rsp_s;

    typedef struct packed {
        logic                    busy;
        logic                    done;
        logic                    fail;
        logic [`FCS_ADDR_W-1:0]  last;
        fcs_flash_req_s          out;
    } fcs_port_s;

    typedef struct packed {
        fcs_state_e              state;
        logic [2:0]              cmd;
        logic                    launch;
        logic [`FCS_ADDR_W-1:0]  addr;
        logic [`FCS_ADDR_W-1:0]  end_addr;
        logic [31:0]             wbuf;
        logic                    area;
        logic                    done;
        logic                    pfail;
        logic                    efail;
        logic                    go;
        logic [31:0]             prdata;
    } fcs_core_s;

endpackage : fcs_pkg

// File: src/fcs_flash_port.sv
// Purpose: drives word writes and block-by-block erases onto the flash array port
// Assumes: array answers each held request with a one-cycle ack (fail alongside)
// Notes:   request drops for one cycle between erase blocks
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"

module fcs_flash_port
    import fcs_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   go,
    input  wire logic                   is_erase,
    input  wire logic                   area,
    input  wire logic [`FCS_ADDR_W-1:0] start_addr,
    input  wire logic [`FCS_ADDR_W-1:0] end_addr,
    input  wire logic [31:0]            wdata,
    input  wire fcs_flash_rsp_s         fl_rsp,
    output var  fcs_flash_req_s         fl_req,
    output logic                        done,
    output logic                        fail
);

    fcs_port_s q;
    fcs_port_s d;
    logic [`FCS_ADDR_W-1:0] blk;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        // erase unit depends on the selected area
        blk    = area ? `FCS_DATA_BLK_BYTES : `FCS_CODE_BLK_BYTES;
        if (!q.busy) begin
            if (go) begin
                d.busy      = 1'b1;
                d.fail      = 1'b0;
                d.out.req   = 1'b1;
                d.out.erase = is_erase;
                d.out.area  = area;
                d.out.wdata = wdata;
                d.last      = end_addr;
                // erase starts at the block holding the start address
                d.out.addr  = is_erase ? (start_addr & ~(blk - 15'h0001)) : start_addr;
            end
        end else if (q.out.req) begin
            if (fl_rsp.ack) begin
                d.out.req = 1'b0;
                if (fl_rsp.fail) begin
                    d.fail = 1'b1;
                end
                if (q.out.erase && ((q.out.addr | (blk - 15'h0001)) < q.last)) begin
                    d.out.addr = q.out.addr + blk;
                end else begin
                    // a write is one word, one request only
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end
            end
        end else begin
            d.out.req = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fl_req = q.out;
    assign done   = q.done;
    assign fail   = q.fail;

endmodule : fcs_flash_port
`default_nettype wire

// File: src/fcs_sequencer.sv
// Purpose: APB-mapped flash command sequencer: registers, command launch, completion
// Assumes: zero-wait APB slave; flash array answers through fcs_flash_port
// Notes:   read data are sampled in the setup cycle of each read
// Function
// - writing launch bit to one starts the selected command
// - codes: 0 none (reset), 1 word write, 4 block erase; others prohibited
// - write command programs the 32-bit buffer at the pointer address
// - code area write programs exactly one 4-byte word
// - data area write programs exactly one 4-byte word
// - erase clears every block from start address to end address
// - data area addresses are offsets from the data area base
// - address pointer 13 or 15 bits, unused high bits read zero
// - end pointer same width, its two low bits read zero
// - write buffer is four byte registers, high byte to low byte
// - control, pointers and buffer bytes reset to zero
// - a code area erase block is 1 Kbyte
// - done flag at status-high bit 6 set when command finishes
// - software clears launch, then device clears done flag
// - write fail at status-low bit 1, erase fail at bit 0
// - area select bit 5: zero code area, one data area
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"

module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter bit WIDE_VARIANT = 1'b1
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`FCS_PADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire fcs_flash_rsp_s          fl_rsp,
    output var  fcs_flash_req_s          fl_req,
    output logic                         busy
);

    localparam logic [`FCS_ADDR_W-1:0] ADDR_MASK =
        WIDE_VARIANT ? `FCS_MASK_WIDE : `FCS_MASK_SMALL;
    localparam logic [`FCS_ADDR_W-1:0] END_MASK  =
        `FCS_END_GRAIN_MASK;

    fcs_core_s q;
    fcs_core_s d;

    logic port_done;
    logic port_fail;
    logic wr_en;
    logic addr_hit;
    logic locked;

    assign wr_en  = psel && penable && pwrite;
    assign locked = (q.state != ST_IDLE);

    always_comb begin
        case (paddr)
            `FCS_OFS_CTRL, `FCS_OFS_ADDR_HI, `FCS_OFS_ADDR_LO,
            `FCS_OFS_END_HI, `FCS_OFS_END_LO, `FCS_OFS_WBUF3,
            `FCS_OFS_WBUF2, `FCS_OFS_WBUF1, `FCS_OFS_WBUF0,
            `FCS_OFS_STAT_HI, `FCS_OFS_STAT_LO, `FCS_OFS_MODE: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    function automatic logic [31:0] read_mux(input fcs_core_s s,
                                             input logic [`FCS_PADDR_W-1:0] a);
        logic [31:0] r;
        r = `FCS_RST_WORD;
        case (a)
            `FCS_OFS_CTRL: begin
                r[`FCS_CTRL_LAUNCH_BIT] = s.launch;
                r[2:0]                  = s.cmd;
            end
            `FCS_OFS_ADDR_HI: r[6:0] = s.addr[14:8];
            `FCS_OFS_ADDR_LO: r[7:0] = s.addr[7:0];
            `FCS_OFS_END_HI:  r[6:0] = s.end_addr[14:8];
            `FCS_OFS_END_LO:  r[7:0] = s.end_addr[7:0];
            `FCS_OFS_WBUF3:   r[7:0] = s.wbuf[31:24];
            `FCS_OFS_WBUF2:   r[7:0] = s.wbuf[23:16];
            `FCS_OFS_WBUF1:   r[7:0] = s.wbuf[15:8];
            `FCS_OFS_WBUF0:   r[7:0] = s.wbuf[7:0];
            `FCS_OFS_STAT_HI: r[`FCS_STH_DONE_BIT] = s.done;
            `FCS_OFS_STAT_LO: begin
                r[`FCS_STL_PFAIL_BIT] = s.pfail;
                r[`FCS_STL_EFAIL_BIT] = s.efail;
            end
            `FCS_OFS_MODE:    r[`FCS_MODE_AREA_BIT] = s.area;
            default:          r = `FCS_RST_WORD;
        endcase
        return r;
    endfunction : read_mux

    always_comb begin
        d    = q;
        d.go = 1'b0;

        if (psel && !penable && !pwrite) begin
            d.prdata = read_mux(q, paddr);
        end

        // register writes; only the launch bit stays writable while locked
        if (wr_en) begin
            case (paddr)
                `FCS_OFS_CTRL: begin
                    d.launch = pwdata[`FCS_CTRL_LAUNCH_BIT];
                    if (!locked) begin
                        d.cmd = pwdata[2:0];
                    end
                end
                `FCS_OFS_ADDR_HI: if (!locked) begin
                    d.addr[14:8] = pwdata[6:0] & ADDR_MASK[14:8];
                end
                `FCS_OFS_ADDR_LO: if (!locked) begin
                    d.addr[7:0] = pwdata[7:0];
                end
                `FCS_OFS_END_HI: if (!locked) begin
                    d.end_addr[14:8] = pwdata[6:0] & ADDR_MASK[14:8];
                end
                `FCS_OFS_END_LO: if (!locked) begin
                    d.end_addr[7:0] = pwdata[7:0] & END_MASK[7:0];
                end
                `FCS_OFS_WBUF3: if (!locked) begin
                    d.wbuf[31:24] = pwdata[7:0];
                end
                `FCS_OFS_WBUF2: if (!locked) begin
                    d.wbuf[23:16] = pwdata[7:0];
                end
                `FCS_OFS_WBUF1: if (!locked) begin
                    d.wbuf[15:8] = pwdata[7:0];
                end
                `FCS_OFS_WBUF0: if (!locked) begin
                    d.wbuf[7:0] = pwdata[7:0];
                end
                `FCS_OFS_MODE: if (!locked) begin
                    d.area = pwdata[`FCS_MODE_AREA_BIT];
                end
                default: ;
            endcase
        end

        case (q.state)
            ST_IDLE: begin
                if (wr_en && (paddr == `FCS_OFS_CTRL) && pwdata[`FCS_CTRL_LAUNCH_BIT]) begin
                    d.pfail = 1'b0;
                    d.efail = 1'b0;
                    if ((pwdata[2:0] == `FCS_CMD_WRITE) ||
                        (pwdata[2:0] == `FCS_CMD_ERASE)) begin
                        d.go    = 1'b1;
                        d.state = ST_RUN;
                    end else begin
                        // no or prohibited command: finish at once, nothing touched
                        d.done  = 1'b1;
                        d.state = ST_DONE;
                    end
                end
            end
            ST_RUN: begin
                if (port_done) begin
                    d.done  = 1'b1;
                    d.state = ST_DONE;
                    if (q.cmd == `FCS_CMD_ERASE) begin
                        d.efail = port_fail;
                    end else begin
                        d.pfail = port_fail;
                    end
                end
            end
            ST_DONE: begin
                if (!q.launch) begin
                    d.done  = 1'b0;
                    d.state = ST_IDLE;
                end
            end
            default: d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // data area addresses pass through unchanged as offsets from its base
    fcs_flash_port u_port (
        .core_clk   (core_clk),
        .rst        (rst),
        .go         (q.go),
        .is_erase   (q.cmd == `FCS_CMD_ERASE),
        .area       (q.area),
        .start_addr (q.addr),
        .end_addr   (q.end_addr),
        .wdata      (q.wbuf),
        .fl_rsp     (fl_rsp),
        .fl_req     (fl_req),
        .done       (port_done),
        .fail       (port_fail)
    );

    assign prdata  = q.prdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign busy    = locked;

    // ---------------- assertions ----------------
    property p_launch;
        @(posedge core_clk) disable iff (rst)
        (q.state == ST_IDLE && wr_en && paddr == `FCS_OFS_CTRL && pwdata[7] &&
         pwdata[2:0] == `FCS_CMD_WRITE) |=> (q.go && q.state == ST_RUN) ##1 fl_req.req;
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch did not start a write");

    property p_codes;
        @(posedge core_clk) disable iff (rst)
        q.go |-> (q.cmd == `FCS_CMD_WRITE || q.cmd == `FCS_CMD_ERASE);
    endproperty
    a_codes: assert property (p_codes)
        else $error("operation started with an invalid code");

    property p_wdata;
        @(posedge core_clk) disable iff (rst)
        ($rose(fl_req.req) && !fl_req.erase) |-> (fl_req.wdata == q.wbuf &&
                                                  fl_req.addr == q.addr);
    endproperty
    a_wdata: assert property (p_wdata)
        else $error("write request does not carry buffer and pointer");

    property p_single_word;
        @(posedge core_clk) disable iff (rst)
        (fl_req.req && !fl_req.erase && fl_rsp.ack) |=> !fl_req.req ##1 !fl_req.req;
    endproperty
    a_single_word: assert property (p_single_word)
        else $error("write issued more than one word");

    property p_erase_start;
        @(posedge core_clk) disable iff (rst)
        ($past(q.go) && fl_req.erase) |-> fl_req.addr == (q.addr & ~(q.area ?
            (`FCS_DATA_BLK_BYTES - 15'h0001) : (`FCS_CODE_BLK_BYTES - 15'h0001)));
    endproperty
    a_erase_start: assert property (p_erase_start)
        else $error("erase did not start at the block of the start address");

    property p_addr_width;
        @(posedge core_clk) disable iff (rst)
        ((q.addr | q.end_addr) & ~ADDR_MASK) == '0;
    endproperty
    a_addr_width: assert property (p_addr_width)
        else $error("unused pointer bits became set");

    property p_end_grain;
        @(posedge core_clk) disable iff (rst)
        q.end_addr[1:0] == 2'b00;
    endproperty
    a_end_grain: assert property (p_end_grain)
        else $error("end pointer low bits not zero");

    property p_done_set;
        @(posedge core_clk) disable iff (rst)
        (q.state == ST_RUN && port_done) |=> q.done && q.state == ST_DONE;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set on completion");

    property p_done_clear;
        @(posedge core_clk) disable iff (rst)
        (q.done && !q.launch) |=> !q.done ##1 (q.state == ST_IDLE || q.go || q.done);
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done flag not cleared after launch cleared");

    property p_fail_report;
        @(posedge core_clk) disable iff (rst)
        (q.state == ST_RUN && port_done && port_fail && q.cmd == `FCS_CMD_ERASE)
            |=> q.efail && !q.pfail;
    endproperty
    a_fail_report: assert property (p_fail_report)
        else $error("erase failure not reported");

    property p_lock;
        @(posedge core_clk) disable iff (rst)
        (locked && wr_en && paddr != `FCS_OFS_CTRL) |=>
            $stable(q.addr) && $stable(q.wbuf) && $stable(q.end_addr);
    endproperty
    a_lock: assert property (p_lock)
        else $error("register changed while a command ran");

    property p_write_fail;
        @(posedge core_clk) disable iff (rst)
        (q.state == ST_RUN && port_done && port_fail && q.cmd == `FCS_CMD_WRITE)
            |=> q.pfail && !q.efail;
    endproperty
    a_write_fail: assert property (p_write_fail)
        else $error("write failure not reported");

    property p_req_hold;
        @(posedge core_clk) disable iff (rst)
        (fl_req.req && !fl_rsp.ack) |=> fl_req.req && $stable(fl_req.addr);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("flash request dropped before its answer");

    property p_no_cmd;
        @(posedge core_clk) disable iff (rst)
        (q.state == ST_IDLE && wr_en && paddr == `FCS_OFS_CTRL && pwdata[7] &&
         pwdata[2:0] != `FCS_CMD_WRITE && pwdata[2:0] != `FCS_CMD_ERASE)
            |=> (q.done && !q.go) ##1 !fl_req.req;
    endproperty
    a_no_cmd: assert property (p_no_cmd)
        else $error("prohibited code reached the flash array");

    property p_launch_erase;
        @(posedge core_clk) disable iff (rst)
        (q.state == ST_IDLE && wr_en && paddr == `FCS_OFS_CTRL && pwdata[7] &&
         pwdata[2:0] == `FCS_CMD_ERASE) |=> q.go ##1 (fl_req.req && fl_req.erase);
    endproperty
    a_launch_erase: assert property (p_launch_erase)
        else $error("launch did not start an erase");

    property p_wbuf_write;
        @(posedge core_clk) disable iff (rst)
        (!locked && wr_en && paddr == `FCS_OFS_WBUF0) |=> q.wbuf[7:0] == $past(pwdata[7:0]);
    endproperty
    a_wbuf_write: assert property (p_wbuf_write)
        else $error("buffer byte not stored");

    c_write_done: cover property (@(posedge core_clk) disable iff (rst)
        q.state == ST_RUN && !fl_req.erase && port_done);
    c_erase_multi: cover property (@(posedge core_clk) disable iff (rst)
        fl_req.erase && fl_rsp.ack ##1 !fl_req.req ##1 fl_req.req);
    c_fail: cover property (@(posedge core_clk) disable iff (rst)
        q.state == ST_RUN && port_done && port_fail);
    c_bad_code: cover property (@(posedge core_clk) disable iff (rst)
        q.state == ST_IDLE ##1 q.state == ST_DONE);

endmodule : fcs_sequencer
`default_nettype wire

// File: tb/fcs_flash_model.sv
// Purpose: behavioural flash array that answers the sequencer's request port
// Assumes: one held request at a time; ack is a one-cycle pulse
// Notes:   answer delay and fail result are set by the bench
`timescale 1ns/1ps
`default_nettype none

module fcs_flash_model
    import fcs_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire fcs_flash_req_s fl_req,
    input  wire logic [3:0]     dly,
    input  wire logic           fail_on,
    output var  fcs_flash_rsp_s fl_rsp,
    output logic [7:0]          n_req,
    output var  fcs_flash_req_s last_req
);
    logic       ack_q;
    logic       fail_q;
    logic [3:0] cnt_q;

    // count each accepted word or block and keep what it carried
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_q    <= 1'b0;
            fail_q   <= 1'b0;
            cnt_q    <= 4'h0;
            n_req    <= 8'h00;
            last_req <= '0;
        end else begin
            ack_q <= 1'b0;
            if (fl_req.req && !ack_q) begin
                if (cnt_q == dly) begin
                    ack_q    <= 1'b1;
                    fail_q   <= fail_on;
                    n_req    <= n_req + 8'h01;
                    last_req <= fl_req;
                    cnt_q    <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end

    // fail only means something beside ack; otherwise show the inverse
    always_comb begin
        fl_rsp.ack  = ack_q;
        fl_rsp.fail = ack_q ? fail_q : ~fail_q;
    end
endmodule : fcs_flash_model

`default_nettype wire

// File: tb/flash_command_sequencer_bench.sv
// Purpose: self-checking bench of the flash command sequencer
// Assumes: wide variant, APB master tasks, flash array model on the far side
// Notes:   register table loop first, then commands, codes and a reset mid-run
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"

module flash_command_sequencer_bench
    import fcs_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  w;
        logic [7:0]  r;
    } fcs_row_s;

    logic           core_clk = 1'b0;
    logic           rst      = 1'b1;
    logic           psel     = 1'b0;
    logic           penable  = 1'b0;
    logic           pwrite   = 1'b0;
    logic [11:0]    paddr    = 12'h000;
    logic [31:0]    pwdata   = 32'h0000_0000;
    logic [31:0]    prdata;
    logic [31:0]    v;
    logic           pready;
    logic           pslverr;
    logic           err;
    logic           busy;
    logic           fail_on  = 1'b0;
    logic [3:0]     dly      = 4'h0;
    logic [7:0]     n_req;
    logic [7:0]     n0;
    fcs_flash_req_s fl_req;
    fcs_flash_req_s last;
    fcs_flash_rsp_s fl_rsp;
    int             failures = 0;
    int             n_tests  = 0;
    int             cyc      = 0;

    fcs_row_s rows [12] = '{
        '{`FCS_OFS_ADDR_HI, 8'hff, 8'h7f}, '{`FCS_OFS_ADDR_LO, 8'hff, 8'hff},
        '{`FCS_OFS_END_HI, 8'hff, 8'h7f},  '{`FCS_OFS_END_LO, 8'hff, 8'hfc},
        '{`FCS_OFS_WBUF3, 8'ha5, 8'ha5},   '{`FCS_OFS_WBUF2, 8'h5a, 8'h5a},
        '{`FCS_OFS_WBUF1, 8'h3c, 8'h3c},   '{`FCS_OFS_WBUF0, 8'hc3, 8'hc3},
        '{`FCS_OFS_MODE, 8'hff, 8'h20},    '{`FCS_OFS_STAT_HI, 8'hff, 8'h00},
        '{`FCS_OFS_STAT_LO, 8'hff, 8'h00}, '{`FCS_OFS_CTRL, 8'h04, 8'h04}
    };

    fcs_sequencer #(.WIDE_VARIANT(1'b1)) uut (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fl_rsp(fl_rsp), .fl_req(fl_req),
        .busy(busy)
    );

    fcs_flash_model flash (
        .core_clk(core_clk), .rst(rst), .fl_req(fl_req), .dly(dly),
        .fail_on(fail_on), .fl_rsp(fl_rsp), .n_req(n_req), .last_req(last)
    );

    always #50 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one APB transfer; read data and error taken at the pready edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        v   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : xfer

    // launch, wait for done, check flags and request count, close handshake
    task automatic run(input logic [7:0] cmd, input logic [7:0] blocks,
                       input logic [7:0] stl, input logic poke);
        n0 = n_req;
        xfer(1'b1, `FCS_OFS_CTRL, {24'h00_0000, cmd});
        if (poke)
            xfer(1'b1, `FCS_OFS_ADDR_LO, 32'h0000_0055);
        v = 32'h0000_0000;
        for (int i = 0; i < 300 && v[6] !== 1'b1; i++)
            xfer(1'b0, `FCS_OFS_STAT_HI, 32'h0000_0000);
        check("status high", v, 32'h0000_0040);
        xfer(1'b0, `FCS_OFS_STAT_LO, 32'h0000_0000);
        check("status low", v, {24'h00_0000, stl});
        check("flash requests", {24'h00_0000, n_req - n0}, {24'h00_0000, blocks});
        xfer(1'b1, `FCS_OFS_CTRL, {24'h00_0000, 1'b0, cmd[6:0]});
        xfer(1'b0, `FCS_OFS_STAT_HI, 32'h0000_0000);
        check("done cleared", v, 32'h0000_0000);
        check("busy", {31'h0, busy}, 32'h0000_0000);
    endtask : run

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (rows[i]) begin
            xfer(1'b0, rows[i].a, 32'h0000_0000);
            check("reset value", v, 32'h0000_0000);
            xfer(1'b1, rows[i].a, {24'hff_ffff, rows[i].w});
            xfer(1'b0, rows[i].a, 32'h0000_0000);
            check("readback", v, {24'h00_0000, rows[i].r});
        end
        xfer(1'b0, 12'h030, 32'h0000_0000);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
        check("unmapped data", v, 32'h0000_0000);
        // code area word write: mode first, then pointers, then launch
        xfer(1'b1, `FCS_OFS_MODE, 32'h0000_0000);
        xfer(1'b1, `FCS_OFS_ADDR_HI, 32'h0000_0008);
        xfer(1'b1, `FCS_OFS_ADDR_LO, 32'h0000_0000);
        run(8'h81, 8'h01, 8'h00, 1'b0);
        check("word", last.wdata, 32'ha55a_3cc3);
        check("target", {17'h0, last.addr}, 32'h0000_0800);
        check("kind", {30'h0, last.erase, last.area}, 32'h0000_0000);
        // data area write, slow failing array, pointer poked while busy
        dly     <= 4'h9;
        fail_on <= 1'b1;
        xfer(1'b1, `FCS_OFS_MODE, 32'h0000_0020);
        xfer(1'b1, `FCS_OFS_ADDR_HI, 32'h0000_0000);
        xfer(1'b1, `FCS_OFS_ADDR_LO, 32'h0000_0004);
        run(8'h81, 8'h01, 8'h02, 1'b1);
        check("data target", {17'h0, last.addr}, 32'h0000_0004);
        check("data kind", {30'h0, last.erase, last.area}, 32'h0000_0001);
        xfer(1'b0, `FCS_OFS_ADDR_LO, 32'h0000_0000);
        check("held pointer", v, 32'h0000_0004);
        // code erase 0x0000..0x0bff spans three 1 Kbyte blocks, failing
        xfer(1'b1, `FCS_OFS_MODE, 32'h0000_0000);
        xfer(1'b1, `FCS_OFS_ADDR_LO, 32'h0000_0000);
        xfer(1'b1, `FCS_OFS_END_HI, 32'h0000_000b);
        xfer(1'b1, `FCS_OFS_END_LO, 32'h0000_00ff);
        run(8'h84, 8'h03, 8'h01, 1'b0);
        check("last block", {17'h0, last.addr}, 32'h0000_0800);
        // data erase 0x0000..0x03ff spans two 512 byte blocks
        dly     <= 4'h0;
        fail_on <= 1'b0;
        xfer(1'b1, `FCS_OFS_MODE, 32'h0000_0020);
        xfer(1'b1, `FCS_OFS_END_HI, 32'h0000_0003);
        run(8'h84, 8'h02, 8'h00, 1'b0);
        check("data block", {16'h0, last.area, last.addr}, 32'h0000_8200);
        // every other code completes without touching the array
        for (int c = 0; c < 8; c++)
            if (c != 1 && c != 4)
                run({5'h10, c[2:0]}, 8'h00, 8'h00, 1'b0);
        // reset in the middle of a slow write
        dly <= 4'hf;
        xfer(1'b1, `FCS_OFS_CTRL, 32'h0000_0081);
        rst <= 1'b1;
        @(negedge core_clk);
        check("reset busy", {31'h0, busy}, 32'h0000_0000);
        check("reset request", {31'h0, fl_req.req}, 32'h0000_0000);
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        xfer(1'b0, `FCS_OFS_CTRL, 32'h0000_0000);
        check("control after reset", v, 32'h0000_0000);
        xfer(1'b0, `FCS_OFS_WBUF3, 32'h0000_0000);
        check("buffer after reset", v, 32'h0000_0000);
        results();
    end
endmodule : flash_command_sequencer_bench

`default_nettype wire
